/* File: hdl/scs_pkg.sv */
// Shared constants of the system clock source switch
package scs_pkg;
	localparam int unsigned HCLK_NS = 4;

	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_STSEL = 8'h04;
	localparam logic [7:0] OFF_OSC = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_CLK = 8'h10;
	localparam logic [7:0] OFF_SUB = 8'h14;
	localparam logic [7:0] OFF_WUT = 8'h18;

	localparam int MODE_EXT_BIT = 7;
	localparam int MODE_XSEL_BIT = 6;
	localparam int MODE_GAIN_BIT = 0;
	localparam int OSC_X1STOP_BIT = 7;
	localparam int OSC_FIXED_BIT = 6;
	localparam int OSC_MID_BIT = 1;
	localparam int OSC_FAST_BIT = 0;
	localparam int CLK_CPU_STAT_BIT = 7;
	localparam int CLK_CPU_SEL_BIT = 6;
	localparam int CLK_MAIN_STAT_BIT = 5;
	localparam int CLK_MCM_BIT = 4;
	localparam int SUB_SLOW_BIT = 0;
	localparam int WUT_SEL_BIT = 4;

	localparam logic [2:0] STSEL_RST = 3'h7;
	localparam logic X1STOP_RST = 1'h1;
	localparam logic SLOW_RST = 1'h1;

	localparam int unsigned STAB_W = 19;

	localparam int unsigned MAIN_SW_NS = 100;
	localparam int unsigned MAIN_SW_CYC = (MAIN_SW_NS + HCLK_NS - 1) / HCLK_NS;
	localparam int unsigned CPU_SW_NS = 134000;
	localparam int unsigned CPU_SW_CYC = (CPU_SW_NS + HCLK_NS - 1) / HCLK_NS;

	// Power of two reached by each stabilisation step
	function automatic logic [4:0] stab_exp(input logic [2:0] idx);
		case (idx)
			3'h0: stab_exp = 5'h08;
			3'h1: stab_exp = 5'h09;
			3'h2: stab_exp = 5'h0a;
			3'h3: stab_exp = 5'h0b;
			3'h4: stab_exp = 5'h0d;
			3'h5: stab_exp = 5'h0f;
			3'h6: stab_exp = 5'h11;
			default: stab_exp = 5'h12;
		endcase
	endfunction
endpackage

/* File: hdl/scs_stab_cnt.sv */
// Crystal stabilisation counter with progressive status flags
`timescale 1ns/1ps
module scs_stab_cnt #(
	parameter int unsigned W = scs_pkg::STAB_W
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic tick,
	input wire logic [2:0] sel,
	output logic [7:0] flags
);
	logic [W-1:0] count_q, count_d;
	logic [7:0] flags_q, flags_d;
	logic [W-1:0] lim;

	always_comb
	begin
		lim = W'(1) << scs_pkg::stab_exp(sel);
		count_d = count_q;
		flags_d = '0;
		if (!run)
			count_d = '0;
		else if (tick && count_q < lim)
			count_d = count_q + W'(1);
		for (int i = 0; i < 8; i++)
		begin
			if (run && count_q >= (W'(1) << scs_pkg::stab_exp(3'(i))))
				flags_d[7-i] = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			count_q <= '0;
			flags_q <= '0;
		end
		else
		begin
			count_q <= count_d;
			flags_q <= flags_d;
		end
	end

	assign flags = flags_q;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	stop_clears_a: assert property (!run |=> flags_q == 8'h00)
		else $error("stabilisation flags not cleared when stopped");
	flags_grow_a: assert property (
		run && $past(run) |-> (flags_q & $past(flags_q)) == $past(flags_q))
		else $error("stabilisation flag dropped while running");
endmodule

/* File: hdl/scs_src_switch.sv */
// Delayed source switchover that reports only a finished change
`timescale 1ns/1ps
module scs_src_switch #(
	parameter int unsigned DLY = scs_pkg::MAIN_SW_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic req,
	output logic stat
);
	localparam int unsigned CW = $clog2(DLY + 2);

	typedef enum logic {SCS_SW_IDLE, SCS_SW_WAIT} scs_sw_t;

	scs_sw_t st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic stat_q, stat_d;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		stat_d = stat_q;
		case (st_q)
			SCS_SW_IDLE:
			begin
				cnt_d = '0;
				if (req != stat_q)
					st_d = SCS_SW_WAIT;
			end
			SCS_SW_WAIT:
			begin
				if (req == stat_q)
					st_d = SCS_SW_IDLE;
				else if (cnt_q == CW'(DLY - 1))
				begin
					stat_d = req;
					st_d = SCS_SW_IDLE;
				end
				else
					cnt_d = cnt_q + CW'(1);
			end
			default: st_d = SCS_SW_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q <= SCS_SW_IDLE;
			cnt_q <= '0;
			stat_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			stat_q <= stat_d;
		end
	end

	assign stat = stat_q;

	// Cycles spent with request and status apart
	logic [CW-1:0] apart_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			apart_q <= '0;
		else if (req != stat_q)
			apart_q <= apart_q + CW'(1);
		else
			apart_q <= '0;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence req_held_s;
		$past(req, 1) == stat_q && $past(req, 2) == stat_q;
	endsequence

	stat_late_a: assert property ($changed(stat_q) |-> req_held_s)
		else $error("status changed before request settled");
	stat_bound_a: assert property (apart_q <= CW'(DLY + 1))
		else $error("switchover took too long");
endmodule

/* File: hdl/scs_clock_switch.sv */
// Clock source switch with AHB-Lite register slave
//
// Overview of operation
// - Stabilisation flags set progressively; software polls for its count.
// - Clearing cpu source select picks main clock over subsystem clock.
// - Read-only status shows cpu source; zero means main clock.
// - Clearing fast oscillator stop bit starts the fast oscillator.
// - Clearing main source select while cpu runs on main clock switches main clock to on-chip oscillator; code ignores it while cpu source select is set.
// - Status shows main source; zero means on-chip oscillator.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module scs_clock_switch #(
	parameter int unsigned CPU_SW_CYC = scs_pkg::CPU_SW_CYC,
	parameter int unsigned MAIN_SW_CYC = scs_pkg::MAIN_SW_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic xtal_tick,
	output logic xtal_osc_en,
	output logic ext_clk_en,
	output logic high_freq_gain,
	output logic fast_osc_en,
	output logic mid_osc_en,
	output logic slow_osc_en,
	output logic main_clk_sel,
	output logic cpu_clk_sel
);
	logic ext_q, ext_d;
	logic xsel_q, xsel_d;
	logic gain_q, gain_d;
	logic [2:0] stsel_q, stsel_d;
	logic x1stop_q, x1stop_d;
	logic mid_q, mid_d;
	logic fstop_q, fstop_d;
	logic cpu_sel_q, cpu_sel_d;
	logic mcm_q, mcm_d;
	logic slow_q, slow_d;
	logic wut_q, wut_d;

	logic wr_pend_q, wr_pend_d;
	logic [7:0] wr_addr_q, wr_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic hreadyout_q;
	logic hresp_q;

	logic xtal_en_q, xtal_en_d;
	logic ext_en_q, ext_en_d;
	logic fast_en_q, fast_en_d;
	logic mid_en_q, mid_en_d;
	logic slow_en_q, slow_en_d;

	logic [7:0] stab_flags;
	logic main_stat;
	logic cpu_stat;
	logic addr_ok;
	logic rd_take;
	logic wr_take;
	logic [7:0] rd_byte;

	scs_stab_cnt #(
		.W(scs_pkg::STAB_W)
	) u_stab (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(xtal_en_q),
		.tick(xtal_tick),
		.sel(stsel_q),
		.flags(stab_flags)
	);

	scs_src_switch #(
		.DLY(MAIN_SW_CYC)
	) u_main_sw (
		.hclk(hclk),
		.hresetn(hresetn),
		.req(mcm_q),
		.stat(main_stat)
	);

	scs_src_switch #(
		.DLY(CPU_SW_CYC)
	) u_cpu_sw (
		.hclk(hclk),
		.hresetn(hresetn),
		.req(cpu_sel_q),
		.stat(cpu_stat)
	);

	// Bus address phase and read data
	always_comb
	begin
		addr_ok = haddr[31:8] == 24'h000000 && hsize == 3'h2;
		rd_take = hsel && hready && htrans[1] && !hwrite;
		wr_take = hsel && hready && htrans[1] && hwrite && addr_ok;
		rd_byte = 8'h00;
		case (haddr[7:0])
			scs_pkg::OFF_MODE:
			begin
				rd_byte[scs_pkg::MODE_EXT_BIT] = ext_q;
				rd_byte[scs_pkg::MODE_XSEL_BIT] = xsel_q;
				rd_byte[scs_pkg::MODE_GAIN_BIT] = gain_q;
			end
			scs_pkg::OFF_STSEL: rd_byte[2:0] = stsel_q;
			scs_pkg::OFF_OSC:
			begin
				rd_byte[scs_pkg::OSC_X1STOP_BIT] = x1stop_q;
				rd_byte[scs_pkg::OSC_FIXED_BIT] = 1'b1;
				rd_byte[scs_pkg::OSC_MID_BIT] = mid_q;
				rd_byte[scs_pkg::OSC_FAST_BIT] = fstop_q;
			end
			scs_pkg::OFF_STAT: rd_byte = stab_flags;
			scs_pkg::OFF_CLK:
			begin
				rd_byte[scs_pkg::CLK_CPU_STAT_BIT] = cpu_stat;
				rd_byte[scs_pkg::CLK_CPU_SEL_BIT] = cpu_sel_q;
				rd_byte[scs_pkg::CLK_MAIN_STAT_BIT] = main_stat;
				rd_byte[scs_pkg::CLK_MCM_BIT] = mcm_q;
			end
			scs_pkg::OFF_SUB: rd_byte[scs_pkg::SUB_SLOW_BIT] = slow_q;
			scs_pkg::OFF_WUT: rd_byte[scs_pkg::WUT_SEL_BIT] = wut_q;
			default: rd_byte = 8'h00;
		endcase
		hrdata_d = '0;
		if (rd_take && addr_ok)
			hrdata_d = {24'h000000, rd_byte};
		wr_pend_d = wr_take;
		wr_addr_d = wr_take ? haddr[7:0] : wr_addr_q;
	end

	// Register writes in the data phase
	always_comb
	begin
		ext_d = ext_q;
		xsel_d = xsel_q;
		gain_d = gain_q;
		stsel_d = stsel_q;
		x1stop_d = x1stop_q;
		mid_d = mid_q;
		fstop_d = fstop_q;
		cpu_sel_d = cpu_sel_q;
		mcm_d = mcm_q;
		slow_d = slow_q;
		wut_d = wut_q;
		if (wr_pend_q)
		begin
			case (wr_addr_q)
				scs_pkg::OFF_MODE:
				begin
					ext_d = hwdata[scs_pkg::MODE_EXT_BIT];
					xsel_d = hwdata[scs_pkg::MODE_XSEL_BIT];
					gain_d = hwdata[scs_pkg::MODE_GAIN_BIT];
				end
				scs_pkg::OFF_STSEL: stsel_d = hwdata[2:0];
				scs_pkg::OFF_OSC:
				begin
					x1stop_d = hwdata[scs_pkg::OSC_X1STOP_BIT];
					mid_d = hwdata[scs_pkg::OSC_MID_BIT];
					fstop_d = hwdata[scs_pkg::OSC_FAST_BIT];
				end
				scs_pkg::OFF_CLK:
				begin
					cpu_sel_d = hwdata[scs_pkg::CLK_CPU_SEL_BIT];
					if (!cpu_stat && !cpu_sel_q)
						mcm_d = hwdata[scs_pkg::CLK_MCM_BIT];
				end
				scs_pkg::OFF_SUB: slow_d = hwdata[scs_pkg::SUB_SLOW_BIT];
				scs_pkg::OFF_WUT: wut_d = hwdata[scs_pkg::WUT_SEL_BIT];
				default: ext_d = ext_q;
			endcase
		end
	end

	// Oscillator enables
	always_comb
	begin
		xtal_en_d = !x1stop_q && xsel_q && !ext_q;
		ext_en_d = !x1stop_q && xsel_q && ext_q;
		fast_en_d = !fstop_q;
		mid_en_d = mid_q;
		slow_en_d = slow_q || wut_q;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_q <= 1'b0;
			xsel_q <= 1'b0;
			gain_q <= 1'b0;
			stsel_q <= scs_pkg::STSEL_RST;
			x1stop_q <= scs_pkg::X1STOP_RST;
			mid_q <= 1'b0;
			fstop_q <= 1'b0;
			cpu_sel_q <= 1'b0;
			mcm_q <= 1'b0;
			slow_q <= scs_pkg::SLOW_RST;
			wut_q <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q <= '0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			xtal_en_q <= 1'b0;
			ext_en_q <= 1'b0;
			fast_en_q <= 1'b1;
			mid_en_q <= 1'b0;
			slow_en_q <= 1'b1;
		end
		else
		begin
			ext_q <= ext_d;
			xsel_q <= xsel_d;
			gain_q <= gain_d;
			stsel_q <= stsel_d;
			x1stop_q <= x1stop_d;
			mid_q <= mid_d;
			fstop_q <= fstop_d;
			cpu_sel_q <= cpu_sel_d;
			mcm_q <= mcm_d;
			slow_q <= slow_d;
			wut_q <= wut_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q <= hrdata_d;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			xtal_en_q <= xtal_en_d;
			ext_en_q <= ext_en_d;
			fast_en_q <= fast_en_d;
			mid_en_q <= mid_en_d;
			slow_en_q <= slow_en_d;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign xtal_osc_en = xtal_en_q;
	assign ext_clk_en = ext_en_q;
	assign high_freq_gain = gain_q;
	assign fast_osc_en = fast_en_q;
	assign mid_osc_en = mid_en_q;
	assign slow_osc_en = slow_en_q;
	assign main_clk_sel = main_stat;
	assign cpu_clk_sel = cpu_stat;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence clk_wr_s;
		wr_pend_q && wr_addr_q == scs_pkg::OFF_CLK;
	endsequence

	cpu_sel_wr_a: assert property (
		clk_wr_s |=> cpu_sel_q == $past(hwdata[scs_pkg::CLK_CPU_SEL_BIT]))
		else $error("cpu source select not written");
	clk_stat_read_a: assert property (
		rd_take && addr_ok && haddr[7:0] == scs_pkg::OFF_CLK
		|=> hrdata_q[scs_pkg::CLK_CPU_STAT_BIT] == $past(cpu_stat)
		&& hrdata_q[scs_pkg::CLK_MAIN_STAT_BIT] == $past(main_stat))
		else $error("clock status read wrong");
	fast_start_a: assert property (!fstop_q |=> fast_osc_en)
		else $error("fast oscillator not started");
	main_switch_a: assert property (
		$fell(mcm_q) |-> ##[1:30] (!main_clk_sel || mcm_q))
		else $error("main clock did not switch to on-chip");
	main_stat_cause_a: assert property (
		$fell(main_clk_sel) |-> !$past(mcm_q, 2))
		else $error("main status fell without request");
	xtal_stop_a: assert property (
		x1stop_q |=> !xtal_osc_en && !ext_clk_en)
		else $error("crystal enable not removed");
	ext_start_a: assert property (
		!x1stop_q && xsel_q && ext_q |=> ext_clk_en && !xtal_osc_en)
		else $error("external clock input not enabled");
	main_guard_a: assert property (
		cpu_stat || cpu_sel_q |=> mcm_q == $past(mcm_q))
		else $error("main select changed on subsystem clock");
	rd_idle_a: assert property (!(rd_take && addr_ok) |=> hrdata_q == 32'h0)
		else $error("read data not cleared after data phase");
	slow_keep_a: assert property (wut_q |=> slow_osc_en)
		else $error("slow oscillator stopped while timer uses it");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus response not ready and okay");
	stab_read_a: assert property (
		rd_take && addr_ok && haddr[7:0] == scs_pkg::OFF_STAT
		|=> hrdata_q[7:0] == $past(stab_flags))
		else $error("stabilisation status read wrong");
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the clock source switch register block
`timescale 1ns/1ps
module testbench;
	logic hclk = 1'b0;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic xtal_tick = 1'b0;
	logic xtal_osc_en;
	logic ext_clk_en;
	logic high_freq_gain;
	logic fast_osc_en;
	logic mid_osc_en;
	logic slow_osc_en;
	logic main_clk_sel;
	logic cpu_clk_sel;
	int failures = 0;
	int checked = 0;

	scs_clock_switch #(
		.CPU_SW_CYC(10),
		.MAIN_SW_CYC(8)
	) i_scs_clock_switch (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hready),
		.hresp(hresp),
		.hrdata(hrdata),
		.xtal_tick(xtal_tick),
		.xtal_osc_en(xtal_osc_en),
		.ext_clk_en(ext_clk_en),
		.high_freq_gain(high_freq_gain),
		.fast_osc_en(fast_osc_en),
		.mid_osc_en(mid_osc_en),
		.slow_osc_en(slow_osc_en),
		.main_clk_sel(main_clk_sel),
		.cpu_clk_sel(cpu_clk_sel)
	);

	always #2 hclk = ~hclk;

	// Crystal period pulse every other cycle
	always @(posedge hclk)
		xtal_tick <= ~xtal_tick;

	task automatic stop_test();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1)
		begin
			check({31'h0, hready}, 32'h1);
			stop_test();
		end
	endtask

	task automatic bus(input logic [7:0] off, input logic wr,
		input logic [31:0] wd, output logic [31:0] rd);
		haddr <= {24'h0, off};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		logic [31:0] r;
		bus(off, 1'b1, {24'h0, d}, r);
	endtask

	task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
		logic [31:0] r;
		bus(off, 1'b0, 32'h0, r);
		check(r, {24'h0, exp});
	endtask

	// Read until the expected value shows, then judge the last read
	task automatic poll(input logic [7:0] off, input logic [7:0] exp);
		logic [31:0] r;
		int n;
		n = 0;
		do
		begin
			bus(off, 1'b0, 32'h0, r);
			n++;
		end
		while (r !== {24'h0, exp} && n < 400);
		check(r, {24'h0, exp});
		if (r !== {24'h0, exp})
			stop_test();
	endtask

	// Outputs in order crystal, ext, gain, fast, mid, slow, main, cpu
	task automatic outs(input logic [7:0] exp);
		repeat (2) @(posedge hclk);
		check({24'h0, xtal_osc_en, ext_clk_en, high_freq_gain, fast_osc_en,
			mid_osc_en, slow_osc_en, main_clk_sel, cpu_clk_sel}, {24'h0, exp});
	endtask

	task automatic reset_values();
		outs(8'h14);
		check({31'h0, hresp}, 32'h0);
		rd_chk(scs_pkg::OFF_MODE, 8'h00);
		rd_chk(scs_pkg::OFF_STSEL, 8'h07);
		rd_chk(scs_pkg::OFF_OSC, 8'hc0);
		rd_chk(scs_pkg::OFF_STAT, 8'h00);
		rd_chk(scs_pkg::OFF_CLK, 8'h00);
		rd_chk(scs_pkg::OFF_SUB, 8'h01);
		rd_chk(scs_pkg::OFF_WUT, 8'h00);
		wr(8'h1c, 8'hff);
		rd_chk(8'h1c, 8'h00);
	endtask

	task automatic crystal_start();
		wr(scs_pkg::OFF_MODE, 8'h40);
		rd_chk(scs_pkg::OFF_MODE, 8'h40);
		wr(scs_pkg::OFF_STSEL, 8'h00);
		wr(scs_pkg::OFF_OSC, 8'h40);
		outs(8'h94);
		rd_chk(scs_pkg::OFF_STAT, 8'h00);
		poll(scs_pkg::OFF_STAT, 8'h80);
		repeat (20) @(posedge hclk);
		rd_chk(scs_pkg::OFF_STAT, 8'h80);
	endtask

	task automatic main_switch();
		wr(scs_pkg::OFF_CLK, 8'h10);
		rd_chk(scs_pkg::OFF_CLK, 8'h10);
		poll(scs_pkg::OFF_CLK, 8'h30);
		outs(8'h96);
		wr(scs_pkg::OFF_OSC, 8'h41);
		outs(8'h86);
		wr(scs_pkg::OFF_OSC, 8'h40);
		outs(8'h96);
		repeat (20) @(posedge hclk);
		wr(scs_pkg::OFF_CLK, 8'h00);
		rd_chk(scs_pkg::OFF_CLK, 8'h20);
		poll(scs_pkg::OFF_CLK, 8'h00);
		wr(scs_pkg::OFF_OSC, 8'hc2);
		outs(8'h1c);
		repeat (4) @(posedge hclk);
		rd_chk(scs_pkg::OFF_STAT, 8'h00);
	endtask

	task automatic cpu_switch();
		wr(scs_pkg::OFF_CLK, 8'h40);
		rd_chk(scs_pkg::OFF_CLK, 8'h40);
		poll(scs_pkg::OFF_CLK, 8'hc0);
		outs(8'h1d);
		wr(scs_pkg::OFF_CLK, 8'h50);
		repeat (20) @(posedge hclk);
		rd_chk(scs_pkg::OFF_CLK, 8'hc0);
		wr(scs_pkg::OFF_CLK, 8'h00);
		rd_chk(scs_pkg::OFF_CLK, 8'h80);
		poll(scs_pkg::OFF_CLK, 8'h00);
		outs(8'h1c);
	endtask

	task automatic slow_and_ext();
		wr(scs_pkg::OFF_WUT, 8'h10);
		wr(scs_pkg::OFF_SUB, 8'h00);
		outs(8'h1c);
		rd_chk(scs_pkg::OFF_SUB, 8'h00);
		wr(scs_pkg::OFF_WUT, 8'h00);
		outs(8'h18);
		wr(scs_pkg::OFF_MODE, 8'hc1);
		wr(scs_pkg::OFF_OSC, 8'h40);
		outs(8'h70);
		rd_chk(scs_pkg::OFF_MODE, 8'hc1);
	endtask

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		reset_values();
		crystal_start();
		main_switch();
		cpu_switch();
		slow_and_ext();
		stop_test();
	end
endmodule
